// ==== ltxs_pkg.sv ====
package ltxs_pkg;
    // register map of the multiplexed parallel bus
    localparam logic [7:0] LTXS_ADDR_LINE_STATUS = 8'h04;
    localparam logic [7:0] LTXS_ADDR_CUR_TX      = 8'h05;
    localparam logic [7:0] LTXS_ADDR_LAST_MSG    = 8'h06;
    localparam logic [7:0] LTXS_READ_NONE        = 8'h00;
    localparam logic [7:0] LTXS_CUR_TX_RST       = 8'h00;
    localparam logic [7:0] LTXS_LAST_MSG_RST     = 8'h00;
    // synchroniser rest levels: strobes rd and wr idle high
    localparam logic [7:0] LTXS_SYNC_AD_RST      = 8'h00;
    localparam logic [3:0] LTXS_SYNC_CTL_RST     = 4'h6;
    localparam logic [2:0] LTXS_SYNC_LINE_RST    = 3'h0;
    // line status field positions
    localparam int LTXS_LS_RX_ACT   = 0;
    localparam int LTXS_LS_TX_ACT   = 1;
    localparam int LTXS_LS_DIAG_A   = 2;
    localparam int LTXS_LS_DIAG_B   = 3;
    localparam int LTXS_LS_MISMATCH = 4;
    localparam int LTXS_LS_IDLE     = 5;
    // nibble layout of both message status registers
    localparam int LTXS_CHAN_LSB  = 0;
    localparam int LTXS_RETRY_LSB = 4;
    localparam int LTXS_NIB_W     = 4;
    // diagnosis encoding of the two line bits
    localparam logic [1:0] LTXS_DIAG_NOMINAL = 2'h0;
    localparam logic [1:0] LTXS_DIAG_MAJOR   = 2'h3;
    // transmission state
    typedef enum logic [1:0] {
        LTXS_TX_IDLE = 2'h1,
        LTXS_TX_BUSY = 2'h2
    } ltxs_tx_state_t;
endpackage : ltxs_pkg

// ==== ltxs_pin_sync.sv ====
module ltxs_pin_sync
    import ltxs_pkg::*;
#(
    parameter int           WIDTH   = 1,
    parameter logic [WIDTH-1:0] RST_VAL = '0
) (
    // clock and reset
    input  wire logic             clk_sys,
    input  wire logic             sys_rst,
    // pins and filtered levels
    input  wire logic [WIDTH-1:0] pin_in,
    output logic      [WIDTH-1:0] level_out
);
    logic [WIDTH-1:0] s1_ff, s2_ff, s3_ff, lvl_ff;
    logic [WIDTH-1:0] nxt_lvl;

    genvar gi;
    generate
        for (gi = 0; gi < WIDTH; gi++) begin : g_bit
            // level moves only when stages two and three agree
            always_comb begin
                nxt_lvl[gi] = (s2_ff[gi] == s3_ff[gi]) ? s3_ff[gi]
                                                       : lvl_ff[gi];
            end
        end
    endgenerate

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            s1_ff  <= RST_VAL;
            s2_ff  <= RST_VAL;
            s3_ff  <= RST_VAL;
            lvl_ff <= RST_VAL;
        end else begin
            s1_ff  <= pin_in;
            s2_ff  <= s1_ff;
            s3_ff  <= s2_ff;
            lvl_ff <= nxt_lvl;
        end
    end

    assign level_out = lvl_ff;
endmodule : ltxs_pin_sync

// ==== ltxs_status.sv ====
// Operation
// - two diagnosis bits: 00 nominal, one set degraded, 11 both faulty
// - sticky mismatch sets when one of three line inputs disagrees while diag_compare_en is high
// - sticky mismatch cleared only by diagnosis reinit or general reset
// - transmit-in-progress from identifier choice until success or limit
// - idle status bit; idle is the state taken after reset
// - current-tx register read-only, reset zero, retries high, channel low
// - last-message register read-only, reset zero, low nibble last channel
// - last-message high nibble holds retries at last tx success, retry limit or reception
module ltxs_status
    import ltxs_pkg::*;
(
    // clock and reset
    input  wire logic       clk_sys,
    input  wire logic       sys_rst,
    // multiplexed host bus pins
    input  wire logic [7:0] ad_in,
    output logic      [7:0] ad_out,
    output logic            ad_oe,
    input  wire logic       ale,
    input  wire logic       rd_n,
    input  wire logic       wr_n,
    input  wire logic       cs,
    // line receive pins
    input  wire logic       line_in_0,
    input  wire logic       line_in_1,
    input  wire logic       line_in_2,
    // diagnosis logic
    input  wire logic       diag_compare_en,
    input  wire logic       diag_reinit,
    input  wire logic       line_diag_bit_a,
    input  wire logic       line_diag_bit_b,
    output logic            input_mismatch_sticky,
    output logic            input_mismatch_alias,
    // mode commands
    input  wire logic       idle_cmd,
    input  wire logic       activate_cmd,
    output logic            idle_state_flag,
    // retry engine
    input  wire logic       tx_start,
    input  wire logic       tx_done_ok,
    input  wire logic       tx_retry_over,
    input  wire logic       rx_done_ok,
    input  wire logic [3:0] cur_retry_count,
    input  wire logic [3:0] cur_channel_num,
    input  wire logic [3:0] rx_channel_num,
    input  wire logic       rx_active,
    output logic            tx_active,
    output logic [3:0]      last_retry_count,
    output logic [3:0]      last_channel_num
);
    ////////////////////////////////////////////////////////////////////////
    // pin synchronisers
    logic [7:0] ad_s;
    logic [3:0] ctl_s;
    logic [2:0] line_s;
    logic       ale_s, rd_s, wr_s, cs_s;

    ltxs_pin_sync #(.WIDTH(8), .RST_VAL(LTXS_SYNC_AD_RST)) u_sync_ad (
        .clk_sys  (clk_sys),
        .sys_rst  (sys_rst),
        .pin_in   (ad_in),
        .level_out(ad_s)
    );
    // rd and wr are active low: rest high
    ltxs_pin_sync #(.WIDTH(4), .RST_VAL(LTXS_SYNC_CTL_RST)) u_sync_ctl (
        .clk_sys  (clk_sys),
        .sys_rst  (sys_rst),
        .pin_in   ({cs, wr_n, rd_n, ale}),
        .level_out(ctl_s)
    );
    ltxs_pin_sync #(.WIDTH(3), .RST_VAL(LTXS_SYNC_LINE_RST)) u_sync_line (
        .clk_sys  (clk_sys),
        .sys_rst  (sys_rst),
        .pin_in   ({line_in_2, line_in_1, line_in_0}),
        .level_out(line_s)
    );
    assign ale_s = ctl_s[0];
    assign rd_s  = ~ctl_s[1];
    assign wr_s  = ~ctl_s[2];
    assign cs_s  = ctl_s[3];

    ////////////////////////////////////////////////////////////////////////
    // status state
    ltxs_tx_state_t tx_st_ff, nxt_tx_st;
    logic       mism_ff, nxt_mism;
    logic       idle_ff, nxt_idle;
    logic [7:0] cur_tx_ff, nxt_cur_tx;
    logic [7:0] last_ff, nxt_last;
    logic       lines_differ;

    function automatic logic [7:0] pack_nib(input logic [3:0] retry,
                                            input logic [3:0] chan);
        logic [7:0] r;
        r = '0;
        r[LTXS_RETRY_LSB +: LTXS_NIB_W] = retry;
        r[LTXS_CHAN_LSB  +: LTXS_NIB_W] = chan;
        return r;
    endfunction : pack_nib

    assign lines_differ = !((line_s[0] == line_s[1]) &&
                            (line_s[1] == line_s[2]));

    always_comb begin
        nxt_tx_st = tx_st_ff;
        unique case (tx_st_ff)
            LTXS_TX_IDLE: begin
                if (tx_start) begin
                    nxt_tx_st = LTXS_TX_BUSY;
                end
            end
            LTXS_TX_BUSY: begin
                if (tx_done_ok || tx_retry_over) begin
                    nxt_tx_st = LTXS_TX_IDLE;
                end
            end
            default: nxt_tx_st = LTXS_TX_IDLE;
        endcase
        // set wins over reinit
        nxt_mism = diag_reinit ? 1'b0 : mism_ff;
        if (diag_compare_en && lines_differ) begin
            nxt_mism = 1'b1;
        end
        nxt_idle = idle_ff;
        if (activate_cmd) begin
            nxt_idle = 1'b0;
        end
        if (idle_cmd) begin
            nxt_idle = 1'b1;
        end
        nxt_cur_tx = pack_nib(cur_retry_count, cur_channel_num);
        nxt_last   = last_ff;
        if (tx_done_ok || tx_retry_over) begin
            nxt_last = pack_nib(cur_retry_count, cur_channel_num);
        end else if (rx_done_ok) begin
            nxt_last = pack_nib(cur_retry_count, rx_channel_num);
        end
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            tx_st_ff  <= LTXS_TX_IDLE;
            mism_ff   <= 1'b0;
            idle_ff   <= 1'b1;
            cur_tx_ff <= LTXS_CUR_TX_RST;
            last_ff   <= LTXS_LAST_MSG_RST;
        end else begin
            tx_st_ff  <= nxt_tx_st;
            mism_ff   <= nxt_mism;
            idle_ff   <= nxt_idle;
            cur_tx_ff <= nxt_cur_tx;
            last_ff   <= nxt_last;
        end
    end

    assign tx_active             = (tx_st_ff == LTXS_TX_BUSY);
    assign input_mismatch_sticky = mism_ff;
    assign input_mismatch_alias  = mism_ff;
    assign idle_state_flag       = idle_ff;
    assign last_retry_count      = last_ff[LTXS_RETRY_LSB +: LTXS_NIB_W];
    assign last_channel_num      = last_ff[LTXS_CHAN_LSB +: LTXS_NIB_W];

    ////////////////////////////////////////////////////////////////////////
    // bus slave: read only, writes ignored
    logic [7:0] addr_ff, nxt_addr;
    logic [7:0] rdata_ff, nxt_rdata;
    logic       ale_d_ff, rd_d_ff;
    logic [7:0] line_word;
    logic       rd_start;

    always_comb begin
        line_word = '0;
        line_word[LTXS_LS_RX_ACT]   = rx_active;
        line_word[LTXS_LS_TX_ACT]   = tx_active;
        line_word[LTXS_LS_DIAG_A]   = line_diag_bit_a;
        line_word[LTXS_LS_DIAG_B]   = line_diag_bit_b;
        line_word[LTXS_LS_MISMATCH] = mism_ff;
        line_word[LTXS_LS_IDLE]     = idle_ff;
    end

    assign rd_start = cs_s && rd_s && !rd_d_ff;

    always_comb begin
        nxt_addr = (ale_d_ff && !ale_s) ? ad_s : addr_ff;
        nxt_rdata = rdata_ff;
        if (rd_start) begin
            unique case (addr_ff)
                LTXS_ADDR_LINE_STATUS: nxt_rdata = line_word;
                LTXS_ADDR_CUR_TX:      nxt_rdata = cur_tx_ff;
                LTXS_ADDR_LAST_MSG:    nxt_rdata = last_ff;
                default:               nxt_rdata = LTXS_READ_NONE;
            endcase
        end
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            addr_ff  <= LTXS_READ_NONE;
            rdata_ff <= LTXS_READ_NONE;
            ale_d_ff <= 1'b0;
            rd_d_ff  <= 1'b0;
        end else begin
            addr_ff  <= nxt_addr;
            rdata_ff <= nxt_rdata;
            ale_d_ff <= ale_s;
            rd_d_ff  <= cs_s && rd_s;
        end
    end

    // wr_s is decoded but no register takes it
    assign ad_out = rdata_ff;
    assign ad_oe  = cs_s && rd_s && rd_d_ff && !wr_s;

    ////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (sys_rst);

    sequence s_tx_begin;
        !tx_active && tx_start;
    endsequence
    sequence s_tx_end;
        tx_active && (tx_done_ok || tx_retry_over);
    endsequence

    chk_tx_enter: assert property (s_tx_begin |=> tx_active)
        else $error("tx_active not raised after start");
    chk_tx_leave: assert property (s_tx_end |=> !tx_active)
        else $error("tx_active not dropped after attempt end");
    chk_mism_set: assert property (
        (diag_compare_en && lines_differ) |=> input_mismatch_sticky)
        else $error("mismatch not flagged");
    chk_mism_hold: assert property (
        (input_mismatch_sticky && !diag_reinit) |=> input_mismatch_sticky)
        else $error("sticky mismatch lost without reinit");
    chk_mism_clr: assert property (
        (diag_reinit && !(diag_compare_en && lines_differ))
        |=> !input_mismatch_sticky)
        else $error("reinit did not clear mismatch");
    chk_idle_reset: assert property (
        $fell(sys_rst) |-> idle_state_flag)
        else $error("device not idle after reset");
    chk_last_load: assert property (
        (tx_done_ok || tx_retry_over) |=>
        last_ff == {$past(cur_retry_count), $past(cur_channel_num)})
        else $error("last message not loaded on attempt end");
    chk_last_rx: assert property (
        (rx_done_ok && !tx_done_ok && !tx_retry_over) |=>
        last_channel_num == $past(rx_channel_num))
        else $error("last channel not loaded on reception");
    chk_last_stable: assert property (
        !(tx_done_ok || tx_retry_over || rx_done_ok) |=> $stable(last_ff))
        else $error("last message changed without event");
    chk_cur_track: assert property (
        1'b1 |=> cur_tx_ff == {$past(cur_retry_count),
                               $past(cur_channel_num)})
        else $error("current transmission register stale");
    chk_diag_view: assert property (
        (rd_start && addr_ff == LTXS_ADDR_LINE_STATUS) |=>
        (ad_out[LTXS_LS_DIAG_B] == $past(line_diag_bit_b)) &&
        (ad_out[LTXS_LS_DIAG_A] == $past(line_diag_bit_a)))
        else $error("diagnosis bits misplaced");
endmodule : ltxs_status

// ==== ltxs_host_model.sv ====
module ltxs_host_model (
    // clock
    input  wire logic       clk_sys,
    // device side of the bus
    input  wire logic [7:0] ad_out,
    input  wire logic       ad_oe,
    // host driven pins
    output wire logic [7:0] ad_in,
    output logic            ale,
    output logic            rd_n,
    output logic            wr_n,
    output logic            cs
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] drv = 8'h5a;
    // wire level: device wins while it drives
    assign ad_in = ad_oe ? ad_out : drv;
    initial begin
        ale = 1'b0;
        rd_n = 1'b1;
        wr_n = 1'b1;
        cs = 1'b0;
    end
    task automatic addr_phase(input logic [7:0] a);
        @(posedge clk_sys);
        drv <= a;
        ale <= 1'b1;
        repeat (6) @(posedge clk_sys);
        ale <= 1'b0;
        repeat (6) @(posedge clk_sys);
    endtask : addr_phase
    task automatic rd(input logic [7:0] a, output logic [7:0] d,
                      output bit ok);
        int n = 0;
        ok = 1'b0;
        addr_phase(a);
        drv <= ~a;
        cs <= 1'b1;
        rd_n <= 1'b0;
        while (!ok && n < 24) begin
            @(posedge clk_sys);
            ok = (ad_oe === 1'b1);
            n++;
        end
        @(posedge clk_sys);
        d = ad_out;
        repeat (4) @(posedge clk_sys);
        cs <= 1'b0;
        rd_n <= 1'b1;
        repeat (8) @(posedge clk_sys);
    endtask : rd
    // only status registers are written, never channel registers
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        addr_phase(a);
        drv <= d;
        cs <= 1'b1;
        wr_n <= 1'b0;
        repeat (6) @(posedge clk_sys);
        cs <= 1'b0;
        wr_n <= 1'b1;
        repeat (6) @(posedge clk_sys);
        drv <= ~d;
    endtask : wr
endmodule : ltxs_host_model

// ==== tb_top.sv ====
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import ltxs_pkg::*;
    logic       clk_sys = 1'b0;
    logic       sys_rst = 1'b1;
    logic [7:0] ad_in, ad_out;
    logic       ad_oe, ale, rd_n, wr_n, cs, sticky, alias_f, idle_f, tx_act;
    logic [2:0] line = 3'h0;
    logic       cmp_en = 1'b0;
    logic [1:0] diag = 2'h0;
    logic [6:0] pls = 7'h00;
    logic [3:0] c_rt = 4'h0, c_ch = 4'h0, rx_ch = 4'h0, l_rt, l_ch;
    logic       rx_act = 1'b0;
    int         bad_count = 0;
    int         n_tests = 0;
    always #25 clk_sys = ~clk_sys;
    ltxs_status i_ltxs_status (.clk_sys(clk_sys), .sys_rst(sys_rst),
        .ad_in(ad_in), .ad_out(ad_out), .ad_oe(ad_oe), .ale(ale),
        .rd_n(rd_n), .wr_n(wr_n), .cs(cs), .line_in_0(line[0]),
        .line_in_1(line[1]), .line_in_2(line[2]), .diag_compare_en(cmp_en),
        .diag_reinit(pls[6]), .line_diag_bit_a(diag[0]),
        .line_diag_bit_b(diag[1]), .input_mismatch_sticky(sticky),
        .input_mismatch_alias(alias_f), .idle_cmd(pls[4]),
        .activate_cmd(pls[5]), .idle_state_flag(idle_f),
        .tx_start(pls[0]), .tx_done_ok(pls[1]), .tx_retry_over(pls[2]),
        .rx_done_ok(pls[3]), .cur_retry_count(c_rt), .cur_channel_num(c_ch),
        .rx_channel_num(rx_ch), .rx_active(rx_act), .tx_active(tx_act),
        .last_retry_count(l_rt), .last_channel_num(l_ch));
    ltxs_host_model i_ltxs_host_model (.clk_sys(clk_sys), .ad_out(ad_out),
        .ad_oe(ad_oe), .ad_in(ad_in), .ale(ale), .rd_n(rd_n), .wr_n(wr_n),
        .cs(cs));
    ////////////////////////////////////////////////////////////////////////
    task automatic end_of_test;
        $display("comparisons %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : end_of_test
    task automatic chk8(input string nm, input logic [7:0] e,
                        input logic [7:0] g);
        n_tests++;
        if (g !== e) begin
            $display("FAIL %s expected %h seen %h", nm, e, g);
            bad_count++;
        end
    endtask : chk8
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
        logic [7:0] d;
        bit ok;
        i_ltxs_host_model.rd(a, d, ok);
        if (!ok) begin
            bad_count++;
            end_of_test();
        end
        chk8($sformatf("register %h", a), e, d);
    endtask : rd_chk
    // one-cycle strobe, then look just after the answering edge
    task automatic pulse(input logic [6:0] m);
        @(posedge clk_sys);
        pls <= m;
        @(posedge clk_sys);
        pls <= 7'h00;
        #1;
    endtask : pulse
    ////////////////////////////////////////////////////////////////////////
    task automatic t_reset;
        chk8("idle", 8'h01, {7'h0, idle_f});
        chk8("tx_active", 8'h00, {7'h0, tx_act});
        rd_chk(LTXS_ADDR_CUR_TX, 8'h00);
        rd_chk(LTXS_ADDR_LAST_MSG, 8'h00);
        rd_chk(8'h0a, 8'h00);
    endtask : t_reset
    task automatic t_diag;
        for (int i = 0; i < 4; i++) begin
            @(posedge clk_sys);
            diag <= i[1:0];
            rx_act <= i[0];
            rd_chk(LTXS_ADDR_LINE_STATUS, {4'h2, i[1:0], 1'b0, i[0]});
        end
        @(posedge clk_sys);
        diag <= 2'h0;
        rx_act <= 1'b0;
    endtask : t_diag
    task automatic t_mismatch;
        @(posedge clk_sys);
        cmp_en <= 1'b1;
        line <= 3'h2;
        repeat (10) @(posedge clk_sys);
        #1;
        chk8("sticky", 8'h01, {7'h0, sticky});
        chk8("alias", 8'h01, {7'h0, alias_f});
        @(posedge clk_sys);
        line <= 3'h0;
        cmp_en <= 1'b0;
        pulse(7'h30);
        repeat (10) @(posedge clk_sys);
        #1;
        chk8("sticky held", 8'h01, {7'h0, sticky});
        pulse(7'h40);
        chk8("sticky cleared", 8'h00, {7'h0, sticky});
    endtask : t_mismatch
    task automatic t_tx;
        @(posedge clk_sys);
        c_rt <= 4'h3;
        c_ch <= 4'h7;
        pulse(7'h01);
        chk8("tx_active", 8'h01, {7'h0, tx_act});
        pulse(7'h01);
        rd_chk(LTXS_ADDR_CUR_TX, 8'h37);
        i_ltxs_host_model.wr(LTXS_ADDR_CUR_TX, 8'hff);
        rd_chk(LTXS_ADDR_CUR_TX, 8'h37);
        rd_chk(LTXS_ADDR_LAST_MSG, 8'h00);
        pulse(7'h02);
        chk8("tx_active", 8'h00, {7'h0, tx_act});
        chk8("last", 8'h37, {l_rt, l_ch});
        i_ltxs_host_model.wr(LTXS_ADDR_LAST_MSG, 8'h00);
        rd_chk(LTXS_ADDR_LAST_MSG, 8'h37);
        @(posedge clk_sys);
        c_rt <= 4'hf;
        c_ch <= 4'h2;
        pulse(7'h01);
        pulse(7'h04);
        chk8("last", 8'hf2, {l_rt, l_ch});
        @(posedge clk_sys);
        c_rt <= 4'h5;
        c_ch <= 4'h4;
        pulse(7'h02);
        chk8("tx_active", 8'h00, {7'h0, tx_act});
        chk8("last", 8'h54, {l_rt, l_ch});
        @(posedge clk_sys);
        rx_ch <= 4'h9;
        pulse(7'h08);
        chk8("last channel", 8'h09, {4'h0, l_ch});
    endtask : t_tx
    task automatic t_idle;
        pulse(7'h20);
        chk8("idle", 8'h00, {7'h0, idle_f});
        rd_chk(LTXS_ADDR_LINE_STATUS, 8'h00);
        pulse(7'h10);
        chk8("idle", 8'h01, {7'h0, idle_f});
    endtask : t_idle
    // general reset in mid-run clears sticky, state and last message
    task automatic t_rerst;
        @(posedge clk_sys);
        cmp_en <= 1'b1;
        line <= 3'h4;
        pulse(7'h21);
        repeat (8) @(posedge clk_sys);
        #1;
        chk8("sticky before reset", 8'h01, {7'h0, sticky});
        chk8("tx_active before reset", 8'h01, {7'h0, tx_act});
        @(posedge clk_sys);
        cmp_en <= 1'b0;
        line <= 3'h0;
        c_rt <= 4'h0;
        c_ch <= 4'h0;
        sys_rst <= 1'b1;
        repeat (4) @(posedge clk_sys);
        sys_rst <= 1'b0;
        chk8("sticky after reset", 8'h00, {7'h0, sticky});
        t_reset();
    endtask : t_rerst
    initial begin
        repeat (12) @(posedge clk_sys);
        sys_rst <= 1'b0;
        t_reset();
        t_diag();
        t_mismatch();
        t_tx();
        t_idle();
        t_rerst();
        end_of_test();
    end
endmodule : tb_top
